// [design/usw_defs.svh]
// Constants for the suspend, wakeup and reset sequencer.
`ifndef USW_DEFS_SVH
`define USW_DEFS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define USW_CLK_HZ 20000000
`define USW_HZ_PER_MHZ 1000000
`define USW_RESUME_US 10000
`define USW_POR_CYC 16

// ---------------------------------------------------------------
// Reset values of the stored configuration
// ---------------------------------------------------------------
`define USW_WAKE_EN_RST 1'b1
`define USW_WAKE_POL_RST 1'b1

`endif

// [design/usw_pkg.sv]
// Types shared by the suspend, wakeup and reset sequencer.
package usw_pkg;

    // -----------------------------------------------------------
    // Power states
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET,
        ST_ACTIVE,
        ST_SUSPEND,
        ST_RESUME
    } usw_state_t;

endpackage

// [design/usw_sync_if.sv]
// Carrier between the input synchroniser and the sequencer.
`timescale 1ns/100ps
interface usw_sync_if;
    logic wake_raw;
    logic ext_rst_n_raw;
    logic wake_pol;
    logic wake_level;
    logic ext_rst_n;

    modport sync (
        input wake_raw,
        input ext_rst_n_raw,
        input wake_pol,
        output wake_level,
        output ext_rst_n
    );

    modport user (
        output wake_raw,
        output ext_rst_n_raw,
        output wake_pol,
        input wake_level,
        input ext_rst_n
    );
endinterface

// [design/usw_sync.sv]
// Two-stage synchroniser for the wake request and external reset.
`timescale 1ns/100ps
module usw_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    usw_sync_if.sync sif
);
    logic [1:0] raw;
    logic [1:0] stage1;
    logic [1:0] stage2;

    // -----------------------------------------------------------
    // Input polarity and two flip-flop chains
    // -----------------------------------------------------------
    // polarity then sync.
    assign raw = {sif.ext_rst_n_raw, sif.wake_raw ^ ~sif.wake_pol};

    for (genvar g = 0; g < 2; g++) begin : g_chain
        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                stage1[g] <= 1'b0;
                stage2[g] <= 1'b0;
            end else if (i_ce) begin
                stage1[g] <= raw[g];
                stage2[g] <= stage1[g];
            end
        end
    end

    assign sif.wake_level = stage2[0];
    assign sif.ext_rst_n = stage2[1];
endmodule

// [design/usw_top.sv]
// Suspend, remote wakeup, clock source and reset sequencer.
// How it works
// - Suspend output high while bus suspended.
// - Bus activity ends suspend at once.
// - Wake request resumes and signals remote wakeup.
// - Remote wakeup only after host enabled it.
// - Descriptor wakeup bit matches stored enable.
// - Stored wake enable and polarity settings.
// - Suspend switches peripherals to low clock.
// - Normal operation runs from main oscillator.
// - Power-on reset loads default known state.
// - External reset low restarts like power-on.
// - Wake enabled by default, can be disabled.
`timescale 1ns/100ps
`include "usw_defs.svh"
module usw_top #(
    parameter int P_RESUME_CYC =
        `USW_RESUME_US * (`USW_CLK_HZ / `USW_HZ_PER_MHZ)
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_external_reset_n,
    input wire logic i_bus_idle,
    input wire logic i_bus_activity,
    input wire logic i_set_feature_rwu,
    input wire logic i_clear_feature_rwu,
    input wire logic i_cfg_wake_en,
    input wire logic i_cfg_wake_pol,
    input wire logic i_wake_req,
    output logic o_suspend,
    output logic o_remote_wake,
    output logic o_desc_rwu,
    output logic o_clk_sel_lf,
    output logic o_osc48_en,
    output logic o_sys_rst_n
);
    localparam int CW = $clog2(P_RESUME_CYC + 1);
    localparam int PW = $clog2(`USW_POR_CYC + 1);

    usw_pkg::usw_state_t state;
    usw_pkg::usw_state_t next_state;
    logic [CW-1:0] resume_cnt;
    logic [PW-1:0] por_cnt;
    logic cfg_wake_en;
    logic cfg_wake_pol;
    logic rwu_armed;
    logic wake_go;
    logic resume_done;

    usw_sync_if sif ();

    // -----------------------------------------------------------
    // Input synchroniser
    // -----------------------------------------------------------
    assign sif.wake_raw = i_wake_req;
    assign sif.ext_rst_n_raw = i_external_reset_n;
    assign sif.wake_pol = cfg_wake_pol;

    usw_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .sif(sif)
    );

    // -----------------------------------------------------------
    // Stored configuration
    // -----------------------------------------------------------
    // load stored settings.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_wake_en <= `USW_WAKE_EN_RST;
            cfg_wake_pol <= `USW_WAKE_POL_RST;
        end else if (i_ce && state == usw_pkg::ST_RESET
                     && por_cnt == '0) begin
            cfg_wake_en <= i_cfg_wake_en;
            cfg_wake_pol <= i_cfg_wake_pol;
        end
    end

    // -----------------------------------------------------------
    // Host enable of remote wakeup
    // -----------------------------------------------------------
    // host arms wakeup.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rwu_armed <= 1'b0;
        end else if (i_ce) begin
            if (!sif.ext_rst_n) begin
                rwu_armed <= 1'b0;
            end else if (i_set_feature_rwu) begin
                rwu_armed <= 1'b1;
            end else if (i_clear_feature_rwu) begin
                rwu_armed <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // Reset stretch
    // -----------------------------------------------------------
    // power-on hold.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_cnt <= PW'(`USW_POR_CYC - 1);
        end else if (i_ce) begin
            if (!sif.ext_rst_n) begin
                por_cnt <= PW'(`USW_POR_CYC - 1);
            end else if (state == usw_pkg::ST_RESET && por_cnt != '0) begin
                por_cnt <= por_cnt - 1'b1;
            end
        end
    end

    // -----------------------------------------------------------
    // Resume signalling timer
    // -----------------------------------------------------------
    assign resume_done = (resume_cnt == '0);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            resume_cnt <= '0;
        end else if (i_ce) begin
            if (next_state == usw_pkg::ST_RESUME
                && state != usw_pkg::ST_RESUME) begin
                resume_cnt <= CW'(P_RESUME_CYC - 1);
            end else if (!resume_done) begin
                resume_cnt <= resume_cnt - 1'b1;
            end
        end
    end

    // -----------------------------------------------------------
    // State sequencing
    // -----------------------------------------------------------
    // wake only when enabled.
    assign wake_go = sif.wake_level && cfg_wake_en && rwu_armed;

    always_comb begin
        next_state = state;
        unique case (state)
            usw_pkg::ST_RESET: begin
                if (por_cnt == '0) begin
                    next_state = usw_pkg::ST_ACTIVE;
                end
            end
            usw_pkg::ST_ACTIVE: begin
                if (i_bus_idle) begin
                    next_state = usw_pkg::ST_SUSPEND;
                end
            end
            usw_pkg::ST_SUSPEND: begin
                if (i_bus_activity) begin
                    next_state = usw_pkg::ST_ACTIVE;
                end else if (wake_go) begin
                    next_state = usw_pkg::ST_RESUME;
                end
            end
            usw_pkg::ST_RESUME: begin
                if (resume_done) begin
                    next_state = usw_pkg::ST_ACTIVE;
                end
            end
        endcase
        if (!sif.ext_rst_n) begin
            next_state = usw_pkg::ST_RESET;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= usw_pkg::ST_RESET;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------
    // Registered outputs
    // -----------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_suspend <= 1'b0;
            o_remote_wake <= 1'b0;
            o_sys_rst_n <= 1'b0;
        end else if (i_ce) begin
            o_suspend <= (next_state == usw_pkg::ST_SUSPEND);
            o_remote_wake <= (next_state == usw_pkg::ST_RESUME);
            o_sys_rst_n <= (next_state != usw_pkg::ST_RESET);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_clk_sel_lf <= 1'b0;
            o_osc48_en <= 1'b1;
        end else if (i_ce) begin
            o_clk_sel_lf <= (next_state == usw_pkg::ST_SUSPEND);
            o_osc48_en <= (next_state != usw_pkg::ST_SUSPEND);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_desc_rwu <= `USW_WAKE_EN_RST;
        end else if (i_ce) begin
            o_desc_rwu <= cfg_wake_en;
        end
    end

    // -----------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_resume_start;
        $rose(o_remote_wake);
    endsequence

    sequence s_resume_hold;
        o_remote_wake [*8];
    endsequence

    a_suspend_entry: assert property (
        (i_ce && state == usw_pkg::ST_ACTIVE && i_bus_idle
         && sif.ext_rst_n) |=> o_suspend && o_clk_sel_lf)
        else $error("suspend not entered on bus idle");

    a_activity_exit: assert property (
        (i_ce && state == usw_pkg::ST_SUSPEND && i_bus_activity
         && sif.ext_rst_n) |=> !o_suspend && !o_remote_wake)
        else $error("suspend not left on bus activity");

    a_wake_signal: assert property (
        (i_ce && state == usw_pkg::ST_SUSPEND && !i_bus_activity
         && wake_go && sif.ext_rst_n) |=> o_remote_wake && !o_suspend)
        else $error("remote wakeup not signalled");

    a_resume_length: assert property (
        s_resume_start |-> s_resume_hold)
        else $error("remote wakeup too short");

    a_wake_armed: assert property (
        $rose(o_remote_wake) |-> $past(rwu_armed))
        else $error("remote wakeup without host enable");

    a_desc_match: assert property (
        $rose(o_sys_rst_n) ##1 i_ce |=> o_desc_rwu == cfg_wake_en)
        else $error("descriptor wakeup bit mismatch");

    a_wake_disabled: assert property (
        (i_ce && !cfg_wake_en && state == usw_pkg::ST_SUSPEND
         && !i_bus_activity && sif.ext_rst_n) |=> o_suspend)
        else $error("wake acted on while disabled");

    a_lf_clock: assert property (
        o_suspend |-> o_clk_sel_lf && !o_osc48_en)
        else $error("suspend without low clock");

    a_hf_clock: assert property (
        (o_sys_rst_n && !o_suspend) |-> o_osc48_en && !o_clk_sel_lf)
        else $error("main oscillator off while active");

    a_por_hold: assert property (
        $rose(o_sys_rst_n) |-> $past(state) == usw_pkg::ST_RESET
                               && $past(por_cnt) == '0)
        else $error("reset released early");

    a_ext_reset: assert property (
        (i_ce && !sif.ext_rst_n) |=> !o_sys_rst_n && !o_suspend
                                     && !rwu_armed)
        else $error("external reset not applied");

    a_wake_gated: assert property (
        $rose(o_remote_wake) |-> $past(state) == usw_pkg::ST_SUSPEND)
        else $error("wake acted on outside suspend");

endmodule

// [dv/usw_host_model.sv]
// Behavioural USB host and local wake logic facing the sequencer.
`timescale 1ns/100ps
module usw_host_model (
    input wire logic i_clk_sys,
    input wire logic i_remote_wake,
    output logic o_bus_idle,
    output logic o_bus_activity,
    output logic o_set_feature_rwu,
    output logic o_clear_feature_rwu,
    output logic o_wake_req
);
    initial begin
        o_bus_idle = 1'b0;
        o_bus_activity = 1'b0;
        o_set_feature_rwu = 1'b0;
        o_clear_feature_rwu = 1'b0;
        o_wake_req = 1'b0;
    end

    always @(posedge i_clk_sys) begin
        if (i_remote_wake === 1'b1) begin
            o_bus_idle <= 1'b0;
        end
    end

    task automatic bus_idle(input logic v);
        @(posedge i_clk_sys);
        o_bus_idle <= v;
    endtask

    task automatic bus_wake();
        @(posedge i_clk_sys);
        o_bus_idle <= 1'b0;
        o_bus_activity <= 1'b1;
        @(posedge i_clk_sys);
        o_bus_activity <= 1'b0;
    endtask

    task automatic feature(input logic arm);
        @(posedge i_clk_sys);
        o_set_feature_rwu <= arm;
        o_clear_feature_rwu <= !arm;
        @(posedge i_clk_sys);
        o_set_feature_rwu <= 1'b0;
        o_clear_feature_rwu <= 1'b0;
    endtask

    task automatic wake(input logic v);
        @(posedge i_clk_sys);
        o_wake_req <= v;
    endtask
endmodule

// [dv/test_usw_top.sv]
// Self-checking bench for the suspend, wakeup and reset sequencer.
`timescale 1ns/100ps
module test_usw_top;
    localparam int P_RESUME = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_rst_n = 1'b1;
    logic ce = 1'b1;
    logic cfg_en = 1'b1;
    logic cfg_pol = 1'b1;
    logic idle, act, set_rwu, clr_rwu, wake_req;
    logic suspend, rwake, desc, clk_lf, osc48, sys_rst_n;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    usw_top #(.P_RESUME_CYC(P_RESUME)) i_usw_top (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_external_reset_n(ext_rst_n), .i_bus_idle(idle),
        .i_bus_activity(act), .i_set_feature_rwu(set_rwu),
        .i_clear_feature_rwu(clr_rwu), .i_cfg_wake_en(cfg_en),
        .i_cfg_wake_pol(cfg_pol), .i_wake_req(wake_req),
        .o_suspend(suspend), .o_remote_wake(rwake), .o_desc_rwu(desc),
        .o_clk_sel_lf(clk_lf), .o_osc48_en(osc48),
        .o_sys_rst_n(sys_rst_n));

    usw_host_model i_usw_host_model (
        .i_clk_sys(clk), .i_remote_wake(rwake), .o_bus_idle(idle),
        .o_bus_activity(act), .o_set_feature_rwu(set_rwu),
        .o_clear_feature_rwu(clr_rwu), .o_wake_req(wake_req));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_int(input string name, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic wait_rst();
        int n;
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        chk("sys_rst_n", 1'b1, sys_rst_n);
        tick();
    endtask

    task automatic t_reset();
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_rst();
        chk("desc_rwu", 1'b1, desc);
        chk("suspend", 1'b0, suspend);
        chk("osc48_en", 1'b1, osc48);
        chk("clk_sel_lf", 1'b0, clk_lf);
        $display("test reset done");
    endtask

    task automatic t_suspend();
        i_usw_host_model.bus_idle(1'b1);
        tick();
        chk("suspend", 1'b1, suspend);
        chk("clk_sel_lf", 1'b1, clk_lf);
        chk("osc48_en", 1'b0, osc48);
        repeat (5) tick();
        chk("suspend held", 1'b1, suspend);
        i_usw_host_model.bus_wake();
        #1;
        chk("suspend", 1'b0, suspend);
        chk("osc48_en", 1'b1, osc48);
        $display("test suspend done");
    endtask

    task automatic t_clock_enable();
        @(posedge clk);
        ce <= 1'b0;
        i_usw_host_model.bus_idle(1'b1);
        repeat (4) tick();
        chk("suspend frozen", 1'b0, suspend);
        chk("osc48_en frozen", 1'b1, osc48);
        @(posedge clk);
        ce <= 1'b1;
        tick();
        chk("suspend", 1'b1, suspend);
        i_usw_host_model.bus_wake();
        #1;
        chk("suspend", 1'b0, suspend);
        $display("test clock enable done");
    endtask

    task automatic try_wake(input logic arm, input logic exp);
        int k;
        int n;
        k = 0;
        n = 0;
        i_usw_host_model.feature(arm);
        i_usw_host_model.bus_idle(1'b1);
        repeat (2) tick();
        i_usw_host_model.wake(cfg_pol);
        while (rwake !== 1'b1 && k < 8) begin
            tick();
            k++;
        end
        chk("remote_wake", exp, rwake);
        if (exp) begin
            chk_int("wake delay", 3, k);
            chk("suspend", 1'b0, suspend);
            while (rwake === 1'b1 && n < 40) begin
                tick();
                n++;
            end
            chk_int("resume length", P_RESUME, n);
        end else begin
            chk("suspend", 1'b1, suspend);
        end
        i_usw_host_model.wake(!cfg_pol);
        if (!exp) begin
            i_usw_host_model.bus_wake();
        end
        tick();
        $display("test wake done");
    endtask

    task automatic t_active_wake();
        i_usw_host_model.feature(1'b1);
        i_usw_host_model.wake(cfg_pol);
        repeat (6) tick();
        chk("remote_wake", 1'b0, rwake);
        chk("suspend", 1'b0, suspend);
        i_usw_host_model.wake(!cfg_pol);
        repeat (3) tick();
        $display("test active wake done");
    endtask

    task automatic t_ext_reset(input logic en, input logic pol);
        i_usw_host_model.bus_idle(1'b1);
        @(posedge clk);
        ext_rst_n <= 1'b0;
        cfg_en <= en;
        cfg_pol <= pol;
        repeat (4) tick();
        chk("sys_rst_n", 1'b0, sys_rst_n);
        chk("suspend", 1'b0, suspend);
        i_usw_host_model.bus_idle(1'b0);
        i_usw_host_model.wake(!pol);
        ext_rst_n <= 1'b1;
        wait_rst();
        chk("desc_rwu", en, desc);
        $display("test external reset done");
    endtask

    initial begin
        t_reset();
        t_suspend();
        t_clock_enable();
        try_wake(1'b0, 1'b0);
        try_wake(1'b1, 1'b1);
        t_active_wake();
        t_ext_reset(1'b0, 1'b1);
        try_wake(1'b1, 1'b0);
        t_ext_reset(1'b1, 1'b0);
        try_wake(1'b1, 1'b1);
        final_report();
    end
endmodule
